// [shared/pbhe_defines.svh]
`ifndef PBHE_DEFINES_SVH
`define PBHE_DEFINES_SVH
// register byte offsets
`define PBHE_CMD_OFF 12'h004
`define PBHE_SSTAT_OFF 12'h01c
`define PBHE_BCTL_OFF 12'h03c
// field positions inside the 32-bit words
`define PBHE_CMD_PRE 6
`define PBHE_CMD_SERR 8
`define PBHE_ST_DPD 24
`define PBHE_ST_SSE 30
`define PBHE_ST_DET 31
`define PBHE_BCTL_PRE 16
// reset values of the enable bits
`define PBHE_PRE_RST 1'h0
`define PBHE_SERR_RST 1'h0
// link cycles from a data transfer to parity-error
`define PBHE_PERR_LAG 2
// bus answers
`define PBHE_RESP_OKAY 2'h0
`define PBHE_RESP_SLVERR 2'h2
`endif

// [shared/pbhe_pkg.sv]
`default_nettype none
package pbhe_pkg;
   // what the bridge core is doing in the current data phase
   typedef enum logic [2:0] {
      K_IDLE, K_CFG0, K_RD_MASTER, K_RD_TARGET, K_DW_INIT
   } pbhe_kind_t;
   typedef enum logic [1:0] {R_NONE, R_CMD, R_SSTAT, R_BCTL} pbhe_reg_t;
   // one pci bus as seen on its pins
   typedef struct packed {
      logic pclk;
      logic addr_phase;
      logic data_phase;
      logic [31:0] ad;
      logic [3:0] cbe;
      logic par;
      logic parity_error_n;
   } pbhe_bus_t;
   // context from the bridge core, same clock as this block
   typedef struct packed {
      pbhe_kind_t kind;
      logic multi;
      logic claim;
   } pbhe_ctx_t;
   // pin drive for one bus, each with its own output enable
   typedef struct packed {
      logic device_select_n;
      logic device_select_oe;
      logic target_ready_n;
      logic target_ready_oe;
      logic stop_n;
      logic stop_oe;
      logic parity_error_n;
      logic parity_error_oe;
      logic par;
      logic par_oe;
   } pbhe_drv_t;
   typedef struct packed {
      logic valid;
      logic [31:0] ad;
      logic [3:0] cbe;
      logic par;
   } pbhe_fwd_t;
   typedef struct packed {
      logic side;
      logic [31:0] addr;
      logic [3:0] cmd;
      logic apar;
      logic [31:0] data;
      logic [3:0] be;
      logic dpar;
   } pbhe_dwq_t;
   // per-bus state on link edges
   typedef struct packed {
      logic calc;
      logic was_addr;
      logic was_data;
      logic multi;
      pbhe_kind_t kind;
      logic [31:0] ad;
      logic [3:0] cbe;
      logic blk;
      logic trdy;
      logic stop;
      logic [31:0] lat_addr;
      logic [3:0] lat_cmd;
      logic lat_apar;
   } pbhe_side_t;
endpackage
`default_nettype wire

// [hw/pbhe_mem.sv]
`timescale 1ns/10ps
`default_nettype none
// small storage with registered read data
module pbhe_mem #(
   parameter int WIDTH = 75,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   generate
      if (DEPTH < 2) begin : g_bad
         $error("pbhe_mem: depth below two");
      end
   endgenerate

   // no reset: contents are only read once written
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// [hw/pbhe_core.sv]
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pbhe_defines.svh"
// Functional notes
// R1: check address parity on every transaction, both buses
// R2: carry observed parity unchanged to other bus
// R3: primary address error: block claim if enabled
// R4: primary address error raises system error if enabled
// R5: secondary address error: block claim if enabled
// R6: secondary address error raises system error if enabled
// R7: config write error: ready, store, flag if enabled
// R8: config write error always sets detected bit
// R9: downstream read error: flag, detect, data-parity bit
// R10: downstream bad data returned with its parity
// R11: upstream read error: flag, detect, data-parity bit
// R12: upstream bad data returned with its parity
// R13: initiator reports bad read data itself
// R14: initiator parity error on returned data ignored
// R15: delayed write captured whole and retried
// R16: bad delayed write, enabled: ready, no queue
// R17: bad delayed write, disabled: retry and queue
// R18: initiator repeats a retried delayed write
// R19: bad delayed write always sets detected bit
// R20: secondary enable lives in bridge control
// R21: even parity, compared one link cycle later
module pbhe_core
   import pbhe_pkg::*;
#(
   parameter int DWQ_DEPTH = 4,
   parameter int PERR_LAG = `PBHE_PERR_LAG
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pbhe_bus_t [1:0] bus,
   input wire pbhe_ctx_t [1:0] ctx,
   output pbhe_drv_t [1:0] drv,
   output pbhe_fwd_t [1:0] fwd,
   output logic primary_system_error_n,
   output logic primary_system_error_oe,
   output logic cfg_store,
   output pbhe_dwq_t dwq_head,
   output logic dwq_valid,
   input wire logic dwq_pop
);
   localparam int AW = $clog2(DWQ_DEPTH);

   generate
      if (DWQ_DEPTH < 2 || (1 << AW) != DWQ_DEPTH) begin : g_bad_depth
         $error("pbhe_core: queue depth must be a power of two");
      end
      if (PERR_LAG < 2) begin : g_bad_lag
         $error("pbhe_core: parity-error lag below two");
      end
   endgenerate

   function automatic logic even_par(input logic [31:0] ad,
                                     input logic [3:0] cbe);
      return ^{ad, cbe};
   endfunction

   function automatic pbhe_reg_t reg_sel(input logic [11:0] a);
      logic [11:0] w;
      w = {a[11:2], 2'h0};
      if (w == `PBHE_CMD_OFF) begin
         return R_CMD;
      end else if (w == `PBHE_SSTAT_OFF) begin
         return R_SSTAT;
      end else if (w == `PBHE_BCTL_OFF) begin
         return R_BCTL;
      end
      return R_NONE;
   endfunction

   pbhe_bus_t [1:0] sync1, sync2;
   logic [1:0] clk_q;
   pbhe_side_t [1:0] side, next_side;
   logic [1:0][PERR_LAG-1:0] perr_sh, next_perr_sh;
   logic [1:0] det, next_det, dpd, next_dpd, pre;
   logic sse, next_sse, serr, next_serr, serr_age, next_serr_age;
   pbhe_fwd_t [1:0] next_fwd;
   logic next_cfg_store;
   logic [1:0] rise, ape, dpe, push;
   logic cmd_pre, next_cmd_pre, cmd_serr, next_cmd_serr;
   logic bctl_pre, next_bctl_pre;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_go, rd_go;
   pbhe_reg_t wsel;
   logic [1:0] clr_det, clr_dpd;
   logic clr_sse;
   logic [AW-1:0] wp, next_wp, rp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic head_ok, next_head_ok, push_go, pop;
   pbhe_dwq_t w_ent;

   // two flops on every pin group; clock and data share the same delay,
   // so a detected link edge pairs with the bus value at that edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '0;
         sync2 <= '0;
         clk_q <= 2'h0;
      end else begin
         sync1 <= bus;
         sync2 <= sync1;
         clk_q <= {sync2[1].pclk, sync2[0].pclk};
      end
   end

   // link edges and parity checks, index 0 primary, 1 secondary
   always_comb begin
      pre = {bctl_pre, cmd_pre}; // see R20
      for (int s = 0; s < 2; s++) begin
         rise[s] = sync2[s].pclk & ~clk_q[s];
         // every address phase is checked, whatever the command; see R1
         ape[s] = rise[s] & side[s].was_addr &
                  (sync2[s].par != side[s].calc); // see R21
         dpe[s] = rise[s] & side[s].was_data &
                  (sync2[s].par != side[s].calc); // see R21
      end
   end

   // software write strobes for the sticky status bits
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign wsel = reg_sel(s_axi_awaddr);
   assign clr_det[0] = wr_go & (wsel == R_CMD) & s_axi_wstrb[3] &
                       s_axi_wdata[`PBHE_ST_DET];
   assign clr_dpd[0] = wr_go & (wsel == R_CMD) & s_axi_wstrb[3] &
                       s_axi_wdata[`PBHE_ST_DPD];
   assign clr_sse = wr_go & (wsel == R_CMD) & s_axi_wstrb[3] &
                    s_axi_wdata[`PBHE_ST_SSE];
   assign clr_det[1] = wr_go & (wsel == R_SSTAT) & s_axi_wstrb[3] &
                       s_axi_wdata[`PBHE_ST_DET];
   assign clr_dpd[1] = wr_go & (wsel == R_SSTAT) & s_axi_wstrb[3] &
                       s_axi_wdata[`PBHE_ST_DPD];

   // per-bus reaction to each link edge; clears come first so a
   // hardware set in the same cycle wins
   always_comb begin
      next_side = side;
      next_perr_sh = perr_sh;
      next_det = det & ~clr_det;
      next_dpd = dpd & ~clr_dpd;
      next_sse = sse & ~clr_sse;
      next_serr = serr;
      next_serr_age = serr_age;
      next_cfg_store = 1'b0;
      push = 2'h0;
      // system error stands for at least one full primary cycle; aged
      // ahead of the checks so a fresh error in the same cycle wins
      if (rise[0] & serr) begin
         next_serr_age = 1'b1;
         if (serr_age) begin
            next_serr = 1'b0;
            next_serr_age = 1'b0;
         end
      end
      for (int s = 0; s < 2; s++) begin
         next_fwd[s] = fwd[s];
         next_fwd[s].valid = 1'b0;
         if (rise[s]) begin
            next_side[s].calc = even_par(sync2[s].ad, sync2[s].cbe);
            next_side[s].was_addr = sync2[s].addr_phase;
            next_side[s].was_data = sync2[s].data_phase;
            next_side[s].kind = ctx[s].kind;
            next_side[s].multi = ctx[s].multi;
            next_side[s].ad = sync2[s].ad;
            next_side[s].cbe = sync2[s].cbe;
            next_side[s].trdy = 1'b0;
            next_side[s].stop = 1'b0;
            next_perr_sh[s] = {perr_sh[s][PERR_LAG-2:0], 1'b0};
            if (side[s].was_addr) begin
               next_side[s].lat_addr = side[s].ad;
               next_side[s].lat_cmd = side[s].cbe;
               next_side[s].lat_apar = sync2[s].par;
               next_side[s].blk = ape[s] & pre[s]; // see R3 R5
            end
            if (ape[s]) begin
               next_det[s] = 1'b1; // see R3 R5
               if (cmd_serr & pre[s]) begin
                  next_sse = 1'b1; // see R4 R6
                  next_serr = 1'b1;
                  next_serr_age = 1'b0;
               end
            end
            if (side[s].was_data) begin
               // data goes across with the parity seen; see R2 R10 R12
               next_fwd[s] = '{1'b1, side[s].ad, side[s].cbe, sync2[s].par};
               case (side[s].kind)
                  K_CFG0: begin
                     next_side[s].trdy = 1'b1; // see R7
                     next_cfg_store = 1'b1;
                     next_perr_sh[s][0] = dpe[s] & pre[s]; // see R7
                     next_det[s] = next_det[s] | dpe[s]; // see R8
                  end
                  K_RD_MASTER: begin
                     next_perr_sh[s][0] = dpe[s] & pre[s]; // see R9 R11
                     next_det[s] = next_det[s] | dpe[s]; // see R9 R11
                     next_dpd[s] = next_dpd[s] | (dpe[s] & pre[s]);
                  end
                  K_DW_INIT: begin
                     next_det[s] = next_det[s] | dpe[s]; // see R19
                     if (dpe[s] & pre[s]) begin
                        next_side[s].trdy = 1'b1; // see R16
                        next_side[s].stop = side[s].multi;
                        next_perr_sh[s][0] = 1'b1;
                     end else begin
                        next_side[s].stop = 1'b1; // see R15 R17
                        push[s] = 1'b1;
                     end
                  end
                  default: begin
                     // returned read data: an initiator parity error
                     // is its own business; see R14
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         side <= '0;
         perr_sh <= '0;
         det <= 2'h0;
         dpd <= 2'h0;
         sse <= 1'b0;
         serr <= 1'b0;
         serr_age <= 1'b0;
         fwd <= '0;
         cfg_store <= 1'b0;
      end else begin
         side <= next_side;
         perr_sh <= next_perr_sh;
         det <= next_det;
         dpd <= next_dpd;
         sse <= next_sse;
         serr <= next_serr;
         serr_age <= next_serr_age;
         fwd <= next_fwd;
         cfg_store <= next_cfg_store;
      end
   end

   // delayed write capture; primary wins a same-cycle clash and the
   // loser is only retried, which its initiator repeats
   always_comb begin
      pop = dwq_pop & dwq_valid;
      push_go = (push[0] | push[1]) & (cnt != DWQ_DEPTH[AW:0]);
      w_ent.side = ~push[0];
      w_ent.addr = push[0] ? side[0].lat_addr : side[1].lat_addr;
      w_ent.cmd = push[0] ? side[0].lat_cmd : side[1].lat_cmd;
      w_ent.apar = push[0] ? side[0].lat_apar : side[1].lat_apar;
      w_ent.data = push[0] ? side[0].ad : side[1].ad;
      w_ent.be = push[0] ? side[0].cbe : side[1].cbe;
      w_ent.dpar = push[0] ? sync2[0].par : sync2[1].par; // see R15
      next_wp = push_go ? wp + 1'b1 : wp;
      next_rp = pop ? rp + 1'b1 : rp;
      next_cnt = cnt + {{AW{1'b0}}, push_go} - {{AW{1'b0}}, pop};
      // read data lag one cycle behind a pointer move
      next_head_ok = ~pop & ~(push_go & (cnt == '0));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         head_ok <= 1'b0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
         head_ok <= next_head_ok;
      end
   end

   assign dwq_valid = (cnt != '0) & head_ok;

   pbhe_mem #(
      .WIDTH($bits(pbhe_dwq_t)),
      .DEPTH(DWQ_DEPTH)
   ) u_dwq (
      .clk(aclk),
      .we(push_go),
      .waddr(wp),
      .wdata(w_ent),
      .raddr(rp),
      .rdata(dwq_head)
   );

   // axi4-lite slave: address and data taken together, answer next cycle
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_go = s_axi_arvalid & ~s_axi_rvalid;

   always_comb begin
      next_cmd_pre = cmd_pre;
      next_cmd_serr = cmd_serr;
      next_bctl_pre = bctl_pre;
      next_bvalid = s_axi_bvalid & ~s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid & ~s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp = (wsel == R_NONE) ? `PBHE_RESP_SLVERR : `PBHE_RESP_OKAY;
         if (wsel == R_CMD && s_axi_wstrb[0]) begin
            next_cmd_pre = s_axi_wdata[`PBHE_CMD_PRE];
         end
         if (wsel == R_CMD && s_axi_wstrb[1]) begin
            next_cmd_serr = s_axi_wdata[`PBHE_CMD_SERR];
         end
         if (wsel == R_BCTL && s_axi_wstrb[2]) begin
            next_bctl_pre = s_axi_wdata[`PBHE_BCTL_PRE]; // see R20
         end
      end
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = `PBHE_RESP_OKAY;
         next_rdata = 32'h0;
         case (reg_sel(s_axi_araddr))
            R_CMD: begin
               next_rdata[`PBHE_CMD_PRE] = cmd_pre;
               next_rdata[`PBHE_CMD_SERR] = cmd_serr;
               next_rdata[`PBHE_ST_DPD] = dpd[0];
               next_rdata[`PBHE_ST_SSE] = sse;
               next_rdata[`PBHE_ST_DET] = det[0];
            end
            R_SSTAT: begin
               next_rdata[`PBHE_ST_DPD] = dpd[1];
               next_rdata[`PBHE_ST_DET] = det[1];
            end
            R_BCTL: begin
               next_rdata[`PBHE_BCTL_PRE] = bctl_pre;
            end
            default: begin
               next_rresp = `PBHE_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_pre <= `PBHE_PRE_RST;
         cmd_serr <= `PBHE_SERR_RST;
         bctl_pre <= `PBHE_PRE_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PBHE_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `PBHE_RESP_OKAY;
         s_axi_rdata <= 32'h0;
      end else begin
         cmd_pre <= next_cmd_pre;
         cmd_serr <= next_cmd_serr;
         bctl_pre <= next_bctl_pre;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end

   // pin drive; a blocked claim leaves the select pin undriven
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         drv[s].device_select_oe = ctx[s].claim & ~side[s].blk; // see R3 R5
         drv[s].device_select_n = ~drv[s].device_select_oe;
         drv[s].target_ready_n = ~side[s].trdy;
         drv[s].target_ready_oe = side[s].trdy | side[s].stop;
         drv[s].stop_n = ~side[s].stop;
         drv[s].stop_oe = side[s].trdy | side[s].stop;
         drv[s].parity_error_n = ~perr_sh[s][PERR_LAG-2];
         drv[s].parity_error_oe = perr_sh[s][PERR_LAG-2];
         drv[s].par = fwd[1-s].par; // see R2
         // only the parity slot after returned data, never an address slot
         drv[s].par_oe = (ctx[s].kind == K_RD_TARGET) & side[s].was_data;
      end
   end

   assign primary_system_error_n = 1'b0;
   assign primary_system_error_oe = serr; // see R4 R6

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_pri_apar_det: assert property (ape[0] |=> det[0]) // see R3
      else $error("primary address error not recorded");
   a_pri_claim_blk: assert property ( // see R3
      rise[0] && side[0].was_addr |=> side[0].blk == $past(ape[0] && cmd_pre))
      else $error("primary claim block wrong");
   a_serr_pri: assert property (ape[0] && cmd_serr && cmd_pre |=> // see R4
      sse && primary_system_error_oe)
      else $error("primary system error missing");
   a_serr_cause: assert property ($rose(serr) |-> // see R6
      $past(cmd_serr) && $past((ape[0] && cmd_pre) || (ape[1] && bctl_pre)))
      else $error("system error without enabled cause");
   a_sec_apar: assert property (ape[1] |=> // see R5
      det[1] && side[1].blk == $past(bctl_pre))
      else $error("secondary address error handling wrong");
   a_cfg_det: assert property (dpe[0] && side[0].kind == K_CFG0 |=> // see R8
      det[0] && side[0].trdy && cfg_store)
      else $error("config write error handling wrong");
   a_cfg_perr: assert property (dpe[0] && side[0].kind == K_CFG0 |=> // see R7
      drv[0].parity_error_oe == $past(cmd_pre))
      else $error("config write parity-error drive wrong");
   a_rd_sec_err: assert property ( // see R9
      dpe[1] && side[1].kind == K_RD_MASTER && bctl_pre |=>
      dpd[1] && det[1] && !drv[1].parity_error_n)
      else $error("downstream read error not reported");
   a_rd_pri_err: assert property ( // see R11
      dpe[0] && side[0].kind == K_RD_MASTER && !cmd_pre |=>
      det[0] && drv[0].parity_error_n)
      else $error("upstream read error reported while disabled");
   a_dw_bad_on: assert property ( // see R16
      dpe[0] && side[0].kind == K_DW_INIT && cmd_pre |->
      !push[0] ##1 side[0].trdy && side[0].stop == $past(side[0].multi))
      else $error("bad delayed write was queued");
   a_dw_bad_off: assert property ( // see R17
      dpe[1] && side[1].kind == K_DW_INIT && !bctl_pre |->
      push[1] ##1 side[1].stop && !side[1].trdy && det[1])
      else $error("bad delayed write not retried");

   c_apar_block: cover property (ape[0] && cmd_pre);
   c_dw_queued: cover property (push_go ##[1:8] dwq_valid);
   c_init_perr: cover property (rise[1] && side[1].kind == K_RD_TARGET &&
      !sync2[1].parity_error_n); // see R14
   c_sec_serr: cover property (ape[1] && cmd_serr && bctl_pre);
endmodule
`default_nettype wire

// [sim/pbhe_pci_agent.sv]
`timescale 1ns/10ps
`default_nettype none
// far-side pci agent; pclk stands low between frames
module pbhe_pci_agent
   import pbhe_pkg::*;
(
   output pbhe_bus_t b
);
   initial b = 41'h1;
   // one link cycle of 160 ns, lines move only while pclk is low
   task automatic tick();
      #80 b.pclk = 1'h1;
      #80 b.pclk = 1'h0;
   endtask
   // address edge, data edge, parity edge; released lines then toggle
   task automatic frame(input logic [31:0] a, d, input logic [3:0] c, e,
         input logic ba, bd, ip);
      #1.3 b = {3'h2, a, c, b.par, 1'h1};
      tick();
      b = {3'h1, d, e, ^{a, c} ^ ba, 1'h1};
      tick();
      b = {3'h0, ~d, ~e, ^{d, e} ^ bd, 1'h1};
      tick();
      b = {3'h0, d, e, ~b.par, ~ip};
      tick();
      b.ad = ~d;
      b.parity_error_n = 1'h1;
      tick();
   endtask
endmodule
`default_nettype wire

// [sim/bridge_parity_error_handler_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pbhe_defines.svh"
module bridge_parity_error_handler_test
   import pbhe_pkg::*;
   ;
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
   logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, dwq_pop = 1'h0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic awready, wready, bvalid, arready, rvalid, cfg_store, dwq_valid;
   logic serr_n, serr_oe;
   logic [1:0] bresp, rresp;
   pbhe_bus_t pb0, pb1;
   pbhe_bus_t [1:0] bus;
   pbhe_ctx_t [1:0] ctx = '0;
   pbhe_drv_t [1:0] drv;
   pbhe_fwd_t [1:0] fwd;
   pbhe_dwq_t dwq_head;
   logic [11:0] seen = '0;
   logic [36:0] fw [2];
   int bad_count = 0, num_checks = 0, seed = 57;
   pbhe_core i_pbhe_core (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .bus(bus), .ctx(ctx), .drv(drv), .fwd(fwd),
      .primary_system_error_n(serr_n), .primary_system_error_oe(serr_oe),
      .cfg_store(cfg_store), .dwq_head(dwq_head), .dwq_valid(dwq_valid),
      .dwq_pop(dwq_pop)
   );
   pbhe_pci_agent i_pbhe_pci_agent0 (.b(pb0));
   pbhe_pci_agent i_pbhe_pci_agent1 (.b(pb1));
   // perr is a wired and; par comes from whoever enables it
   always_comb begin
      bus = {pb1, pb0};
      for (int i = 0; i < 2; i++) begin
         bus[i].parity_error_n &= ~(drv[i].parity_error_oe &
            ~drv[i].parity_error_n);
         if (drv[i].par_oe) bus[i].par = drv[i].par;
      end
   end
   initial forever #2 aclk = ~aclk;
   // short pulses are latched so a frame is judged after it ends
   always @(posedge aclk) begin
      for (int i = 0; i < 2; i++) begin
         seen[4*i+:4] <= seen[4*i+:4] | {drv[i].stop_oe & ~drv[i].stop_n,
            drv[i].target_ready_oe & ~drv[i].target_ready_n,
            drv[i].parity_error_oe & ~drv[i].parity_error_n, ctx[i].claim
            & ~(drv[i].device_select_oe & ~drv[i].device_select_n)};
         if (fwd[i].valid) fw[i] <= {fwd[i].ad, fwd[i].cbe, fwd[i].par};
      end
      seen[11:8] <= seen[11:8] | {fwd[1].valid, fwd[0].valid,
         serr_oe & ~serr_n, cfg_store};
   end
   task automatic chk(input logic [74:0] got, input logic [74:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (bad_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // write: address and data offered together and held until taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      while (!bvalid) @(posedge aclk);
      bready <= 1'h0;
      chk(bresp, `PBHE_RESP_OKAY);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge aclk);
      rready <= 1'h0;
      chk({rresp, rdata}, {er, ed});
   endtask
   // mask in the upper half, flags below: stop, ready, perr, blocked
   function automatic logic [23:0] expect_seen(input logic s, ba, bd, pre,
         se, mu, sh, input pbhe_kind_t k);
      logic [3:0] v, m;
      logic f;
      f = k == K_RD_MASTER;
      m = {k == K_DW_INIT, k == K_DW_INIT || k == K_CFG0, 2'h3};
      v = {k == K_DW_INIT && !(bd && pre && !mu), k == K_CFG0 ||
         k == K_DW_INIT && bd && pre, bd && pre && k != K_RD_TARGET, ba && pre};
      return {f & s, f & !s, !sh, 1'h1, s ? {m, 4'hf} : {4'hf, m},
         f & s, f & !s, ba & pre & se, k == K_CFG0, s ? {v, 4'h0} : {4'h0, v}};
   endfunction
   // random frames; the first 24 are steered onto the error corners
   initial begin
      logic [31:0] r, a, d, en;
      logic [23:0] x;
      logic [3:0] c, e;
      logic s, pre, se, mu, ip, ba, bd, sh;
      pbhe_kind_t k;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`PBHE_SSTAT_OFF, 32'h0, `PBHE_RESP_OKAY);
      rd(12'h100, 32'h0, `PBHE_RESP_SLVERR);
      for (int n = 0; n < 48; n++) begin
         a = $random(seed);
         d = $random(seed);
         r = $random(seed);
         {c, e, ip, mu, bd, se, pre, s} = r[13:0];
         ba = r[16:14] == 3'h0;
         k = pbhe_kind_t'(3'(r[18:17]) + 3'h1);
         if (n < 8) begin
            {s, se, pre} = 3'(n);
            ba = 1'h1;
         end else if (n < 24) begin
            {ba, bd} = 2'h1;
            k = pbhe_kind_t'(3'(n[3:2]) + 3'h1);
         end
         if (ba) begin
            bd = 1'h0;
            k = K_IDLE;
         end
         if (k == K_CFG0) s = 1'h0;
         ip &= k == K_RD_TARGET;
         en = {23'h0, se, 1'h0, pre, 6'h0};
         wr(`PBHE_CMD_OFF, en);
         wr(`PBHE_BCTL_OFF, {15'h0, pre, 16'h0});
         rd(`PBHE_BCTL_OFF, {15'h0, pre, 16'h0}, `PBHE_RESP_OKAY);
         sh = serr_oe;
         ctx[s] <= '{kind: k, multi: mu, claim: 1'h1};
         #1 seen = '0;
         // a block left by an earlier frame lasts until the link edge after this address
         fork
            begin
               repeat (80) @(posedge aclk);
               #1 seen[4*s] = 1'h0;
            end
         join_none
         // a retried delayed write is repeated by its initiator
         repeat (1 + int'(k == K_DW_INIT && !(bd && pre))) begin
            if (s) i_pbhe_pci_agent1.frame(a, d, c, e, ba, bd, ip);
            else i_pbhe_pci_agent0.frame(a, d, c, e, ba, bd, ip);
         end
         ctx[s] <= '0;
         repeat (12) @(posedge aclk);
         x = expect_seen(s, ba, bd, pre, se, mu, sh, k);
         chk(seen & x[23:12], x[11:0] & x[23:12]);
         rd(`PBHE_CMD_OFF, en | {!s & (ba | bd & k != K_RD_TARGET),
            ba & pre & se, 5'h0, !s & bd & pre & k == K_RD_MASTER, 24'h0},
            `PBHE_RESP_OKAY);
         if (s) rd(`PBHE_SSTAT_OFF, {ba | bd & k != K_RD_TARGET, 6'h0,
            bd & pre & k == K_RD_MASTER, 24'h0}, `PBHE_RESP_OKAY);
         wr(`PBHE_CMD_OFF, en | 32'hc1000000);
         wr(`PBHE_SSTAT_OFF, 32'h81000000);
         chk(dwq_valid, k == K_DW_INIT && !(bd && pre));
         if (dwq_valid === 1'h1) begin
            chk(dwq_head, pbhe_dwq_t'{side: s, addr: a, cmd: c,
               apar: ^{a, c}, data: d, be: e, dpar: ^{d, e} ^ bd});
            // held four edges so the repeated write drains as well
            @(posedge aclk) dwq_pop <= 1'h1;
            repeat (4) @(posedge aclk);
            dwq_pop <= 1'h0;
         end
         if (k == K_RD_MASTER) chk(fw[s], {d, e, ^{d, e} ^ bd});
      end
      final_report();
   end
   // a hang counts as a mismatch and ends through the same report
   initial begin
      #150000;
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
